// >>> core/rtseq_top.sv
// reset and start-up time-out sequencer with reset-cause register
// assumes supply monitor, pin and core event inputs synchronous to hclk
`timescale 1ns/10ps

// Overview of operation
// - supply rise detect makes power-on pulse
// - reset held while power-up timer counts
// - config bit skips the 72 ms delay
// - oscillator count 1024 input edges after delay
// - oscillator count only crystal modes, power/wake
// - PLL lock wait 2 ms after oscillator count
// - brown-out enable bit gates brown-out reset
// - brown-out reset held while supply low
// - brown-out during delay restarts the timer
// - power-up delay first, then oscillator count
// - RC mode, delay disabled: no time-out
// - time-outs ignore pin; pin release starts
// - external clock wake has 1.5 us recovery
// - cause register bit layout, bits 6:5 zero
// - power-on and brown-out flag values
// - pin reset: PC zero, priority cleared
// - software reset clears its flag, PC zero
// - stack reset sets stack flag, PC zero
// - pin reset in sleep: watchdog 1, pd 0
// - interrupt wake: TO set, PD cleared, PC plus two
// - interrupt wake with global enable loads vector
// - pin filtered, never driven by device
module rtseq_top #(
  parameter int POWERUP_TIMER_TICKS = rtseq_pkg::POWERUP_TIMER_TICKS_DEF,
  parameter int PLL_TICKS  = rtseq_pkg::PLL_TICKS_DEF,
  parameter int CNT_W      = 24
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [7:0]                 haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       supply_rise_detect,
  input  wire logic                       supply_below_threshold,
  input  wire logic                       ext_reset_pin_n,
  input  wire logic                       osc_input,
  input  wire logic                       sleep_active,
  input  wire logic                       sw_reset_req,
  input  wire logic                       wdog_expiry,
  input  wire logic                       stack_overflow,
  input  wire logic                       stack_underflow,
  input  wire logic                       int_wake,
  input  wire logic                       int_wake_high,
  input  wire logic                       high_priority_global_enable,
  input  wire logic                       low_priority_global_enable,
  input  wire logic [rtseq_pkg::PC_W-1:0] pc_current,
  output logic                            chip_reset,
  output logic                            wake_stall,
  output logic                            pc_load,
  output logic [rtseq_pkg::PC_W-1:0]      pc_value
);
  import rtseq_pkg::*;

  initial begin
    if (POWERUP_TIMER_TICKS < 1 || PLL_TICKS < 1 || POWERUP_TIMER_TICKS >= (1 << CNT_W) ||
        PLL_TICKS >= (1 << CNT_W) || OST_CYCLES >= (1 << CNT_W))
      $error("rtseq_top: counts do not fit the sequence counter");
  end

  rtseq_state_type      state_q, state_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic                 in_wake_q, in_wake_d;
  logic [7:0]           reset_cause_control_q;
  logic [6:0]           cfg_q;
  logic [1:0]           stk_q;
  logic [6:0]           rc_cnt_q;
  logic                 rc_tick_q;
  logic                 rise_q;
  logic                 osc_q;
  logic                 pin_low_q;
  logic [2:0]           filt_cnt_q;
  logic                 wr_pend_q;
  logic [7:0]           wr_addr_q;
  logic                 chip_reset_d;
  logic                 wake_stall_d;
  rtseq_osc_type        osc_mode;
  logic                 crystal;
  logic                 por_pulse;
  logic                 bor_qual;
  logic                 bor_evt;
  logic                 osc_edge;
  logic                 pin_low_d;
  logic                 ext_reset_pin_n_evt;
  logic                 run_awake;
  logic                 wdt_rst_evt;
  logic                 stk_evt;
  logic                 sw_evt;
  logic                 wake_evt;
  logic                 ext_reset_pin_n_sleep_evt;
  logic                 acc_ok;
  logic [31:0]          rd_d;

  assign osc_mode  = rtseq_osc_type'(cfg_q[CFG_MODE_LSB +: 3]);
  assign crystal   = (osc_mode == OSC_LP) || (osc_mode == OSC_XT) ||
                     (osc_mode == OSC_HS);
  assign por_pulse = supply_rise_detect & ~rise_q;
  assign bor_qual  = cfg_q[CFG_BROWNOUT_ENABLE_BIT] & supply_below_threshold;
  assign bor_evt   = bor_qual & (state_q != ST_BROWN) & ~por_pulse;
  assign osc_edge  = osc_input & ~osc_q;
  assign ext_reset_pin_n_evt  = pin_low_d & ~pin_low_q;
  assign run_awake = (state_q == ST_RUN) & ~por_pulse & ~bor_qual;
  assign ext_reset_pin_n_sleep_evt = run_awake & ext_reset_pin_n_evt & sleep_active;
  assign wdt_rst_evt = run_awake & ~ext_reset_pin_n_evt & wdog_expiry & ~sleep_active;
  assign stk_evt   = run_awake & ~ext_reset_pin_n_evt & ~sleep_active & ~wdog_expiry &
                     (stack_overflow | stack_underflow);
  assign sw_evt    = run_awake & ~ext_reset_pin_n_evt & ~sleep_active & ~wdog_expiry &
                     ~stack_overflow & ~stack_underflow & sw_reset_req;
  assign wake_evt  = run_awake & ~ext_reset_pin_n_evt & sleep_active &
                     (int_wake | wdog_expiry);

  // internal RC clock as an enable pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_cnt_q  <= 7'h00;
      rc_tick_q <= 1'b0;
    end else begin
      rc_tick_q <= (rc_cnt_q == 7'(RC_DIV_CYCLES - 1));
      if (rc_cnt_q == 7'(RC_DIV_CYCLES - 1))
        rc_cnt_q <= 7'h00;
      else
        rc_cnt_q <= rc_cnt_q + 7'h01;
    end
  end

  // edge history of supply detect and oscillator input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_q <= 1'b0;
      osc_q  <= 1'b0;
    end else begin
      rise_q <= supply_rise_detect;
      osc_q  <= osc_input;
    end
  end

  // pin noise filter: level must persist before it is believed;
  // the pin is input only, nothing here can pull it low
  always_comb begin
    pin_low_d = pin_low_q;
    if ((ext_reset_pin_n == pin_low_q) &&
        (filt_cnt_q == 3'(PIN_FILT_CYCLES - 1)))
      pin_low_d = ~pin_low_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_low_q  <= 1'b0;
      filt_cnt_q <= 3'h0;
    end else begin
      pin_low_q <= pin_low_d;
      if (ext_reset_pin_n != pin_low_q || pin_low_d != pin_low_q)
        filt_cnt_q <= 3'h0;
      else
        filt_cnt_q <= filt_cnt_q + 3'h1;
    end
  end

  // sequencer next state
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    in_wake_d = in_wake_q;
    if (por_pulse || (state_q == ST_BROWN && !bor_qual)) begin
      in_wake_d = 1'b0;
      cnt_d     = '0;
      if (!cfg_q[CFG_DLYDIS_BIT])
        state_d = ST_POWERUP_TIMER;
      else if (crystal)
        state_d = ST_OST;
      else
        state_d = ST_RUN;
    end else if (bor_qual) begin
      state_d   = ST_BROWN;
      in_wake_d = 1'b0;
      cnt_d     = '0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wake_evt || ext_reset_pin_n_sleep_evt) begin
            in_wake_d = wake_evt;
            cnt_d     = '0;
            if (crystal)
              state_d = ST_OST;
            else if (osc_mode == OSC_EC)
              state_d = ST_ECREC;
            else
              state_d = ST_SHORT;
          end else if (wdt_rst_evt || stk_evt || sw_evt) begin
            state_d = ST_SHORT;
          end
        end
        ST_POWERUP_TIMER: begin
          if (rc_tick_q) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(POWERUP_TIMER_TICKS - 1)) begin
              cnt_d   = '0;
              state_d = crystal ? ST_OST : ST_RUN;
            end
          end
        end
        ST_OST: begin
          if (osc_edge) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(OST_CYCLES - 1)) begin
              cnt_d = '0;
              if (cfg_q[CFG_PLL_BIT] && osc_mode == OSC_HS)
                state_d = ST_PLL;
              else
                state_d = ST_RUN;
            end
          end
        end
        ST_PLL: begin
          if (rc_tick_q) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(PLL_TICKS - 1)) begin
              cnt_d   = '0;
              state_d = ST_RUN;
            end
          end
        end
        ST_ECREC: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(EC_REC_CYCLES - 1)) begin
            cnt_d   = '0;
            state_d = ST_RUN;
          end
        end
        ST_SHORT: state_d = ST_RUN;
        default:  state_d = ST_RUN;
      endcase
    end
    if (state_d == ST_RUN)
      in_wake_d = 1'b0;
  end

  // reset is held through every time-out except a wake's, where wake_stall holds instead, and also by the pin;
  // the time-outs themselves never wait for the pin
  assign chip_reset_d = (~in_wake_d & (state_d != ST_RUN)) | pin_low_d;
  assign wake_stall_d = in_wake_d & (state_d != ST_RUN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ST_POWERUP_TIMER;
      cnt_q     <= '0;
      in_wake_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      in_wake_q <= in_wake_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_reset <= 1'b1;
      wake_stall <= 1'b0;
      pc_load    <= 1'b0;
    end else begin
      chip_reset <= chip_reset_d;
      wake_stall <= wake_stall_d;
      pc_load    <= (chip_reset & ~chip_reset_d) |
                    (wake_stall & ~wake_stall_d);
    end
  end

  // program counter to load when the core restarts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_value <= PC_RESET;
    end else if (wake_evt) begin
      if (int_wake && (high_priority_global_enable ||
                       low_priority_global_enable))
        pc_value <= int_wake_high ? VEC_HIGH : VEC_LOW;
      else
        pc_value <= pc_current + PC_STEP;
    end else if (por_pulse || bor_evt || ext_reset_pin_n_evt || wdt_rst_evt ||
                 stk_evt || sw_evt) begin
      pc_value <= PC_RESET;
    end
  end

  // bus write staged from address phase to data phase
  assign acc_ok = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc_ok & hwrite & (hsize == 3'h2);
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cfg_q <= CFG_RESET;
    else if (wr_pend_q && wr_addr_q == ADDR_CFG)
      cfg_q <= hwdata[6:0];
  end

  // software write first, hardware cause last so a cause always wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_cause_control_q <= RESET_CAUSE_CONTROL_RESET;
    end else begin
      reset_cause_control_q <= reset_cause_control_q;
      if (wr_pend_q && wr_addr_q == ADDR_RESET_CAUSE_CONTROL)
        reset_cause_control_q <= hwdata[7:0] & RESET_CAUSE_CONTROL_MASK;
      if (por_pulse) begin
        reset_cause_control_q[4:0]      <= FLAGS_POR;
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (bor_evt) begin
        reset_cause_control_q[RI_BIT]   <= 1'b1;
        reset_cause_control_q[TO_BIT]   <= 1'b1;
        reset_cause_control_q[PD_BIT]   <= 1'b1;
        reset_cause_control_q[POR_BIT]  <= 1'b1;
        reset_cause_control_q[BOR_BIT]  <= 1'b0;
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (ext_reset_pin_n_sleep_evt) begin
        reset_cause_control_q[TO_BIT]   <= 1'b1;
        reset_cause_control_q[PD_BIT]   <= 1'b0;
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (ext_reset_pin_n_evt && run_awake) begin
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (wdt_rst_evt) begin
        reset_cause_control_q[RI_BIT]   <= 1'b1;
        reset_cause_control_q[TO_BIT]   <= 1'b0;
        reset_cause_control_q[PD_BIT]   <= 1'b1;
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (stk_evt) begin
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (sw_evt) begin
        reset_cause_control_q[RI_BIT]   <= 1'b0;
        reset_cause_control_q[INT_PRIORITY_ENABLE_BIT] <= 1'b0;
      end else if (wake_evt) begin
        reset_cause_control_q[TO_BIT]   <= ~wdog_expiry;
        reset_cause_control_q[PD_BIT]   <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stk_q <= 2'h0;
    end else begin
      stk_q <= stk_q;
      if (wr_pend_q && wr_addr_q == ADDR_STACK)
        stk_q <= hwdata[1:0];
      if (stk_evt && stack_overflow)
        stk_q[STK_OVF_BIT] <= 1'b1;
      if (stk_evt && stack_underflow)
        stk_q[STK_UNF_BIT] <= 1'b1;
    end
  end

  // read data is prepared in the address phase so it leaves a flop
  always_comb begin
    rd_d = 32'h00000000;
    if (haddr == ADDR_RESET_CAUSE_CONTROL)
      rd_d[7:0] = reset_cause_control_q & RESET_CAUSE_CONTROL_MASK;
    else if (haddr == ADDR_CFG)
      rd_d[6:0] = cfg_q;
    else if (haddr == ADDR_STAT)
      rd_d[15:0] = {1'b0, state_q, 5'h00, pin_low_q, wake_stall,
                    chip_reset};
    else if (haddr == ADDR_STACK)
      rd_d[1:0] = stk_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc_ok && !hwrite)
        hrdata <= rd_d;
    end
  end

  a_powerup_timer_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_POWERUP_TIMER && !in_wake_q |-> chip_reset)
    else $error("reset not held while power-up timer runs");
  a_dly_skip: assert property (@(posedge hclk) disable iff (!hresetn)
    por_pulse && cfg_q[CFG_DLYDIS_BIT] && !bor_qual |=> state_q != ST_POWERUP_TIMER)
    else $error("power-up delay not skipped");
  a_ost_length: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(state_q) == ST_OST && (state_q == ST_RUN || state_q == ST_PLL)
    |-> $past(cnt_q) == CNT_W'(OST_CYCLES - 1) && $past(osc_edge))
    else $error("oscillator count left early");
  a_bor_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    bor_qual && !por_pulse |=> state_q == ST_BROWN && chip_reset)
    else $error("brown-out did not hold reset");
  a_rc_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    por_pulse && cfg_q[CFG_DLYDIS_BIT] && osc_mode == OSC_RC && !bor_qual
    |=> state_q == ST_RUN)
    else $error("RC mode applied a time-out");
  a_por_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    por_pulse |=> reset_cause_control_q[4:0] == FLAGS_POR && !reset_cause_control_q[INT_PRIORITY_ENABLE_BIT])
    else $error("power-on flags wrong");
  a_sw_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_evt |=> !reset_cause_control_q[RI_BIT] && pc_value == PC_RESET ##1 pc_load)
    else $error("software reset flags or PC wrong");
  a_wake_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_evt && int_wake && !wdog_expiry
    |=> reset_cause_control_q[TO_BIT] && !reset_cause_control_q[PD_BIT])
    else $error("interrupt wake flags wrong");
  a_wdt_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    wdt_rst_evt |=> reset_cause_control_q[4:2] == 3'h5)
    else $error("watchdog reset flags wrong");
  a_pin_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_reset_pin_n_sleep_evt |=> reset_cause_control_q[TO_BIT] && !reset_cause_control_q[PD_BIT] && chip_reset)
    else $error("pin reset in sleep flags wrong");

  c_pll_wait: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_PLL ##1 state_q == ST_RUN);
  c_wake_vec: cover property (@(posedge hclk) disable iff (!hresetn)
    wake_evt && int_wake && high_priority_global_enable);
  c_bor_restart: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_POWERUP_TIMER && bor_qual);

endmodule

// >>> include/rtseq_pkg.sv
// constants, field layout and types of the reset and time-out sequencer
// assumes a 100 MHz hclk and an AHB-Lite register port with 32-bit data
package rtseq_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_RESET_CAUSE_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_CFG   = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_STACK = 8'h0c;

  // reset_cause_control layout
  localparam int INT_PRIORITY_ENABLE_BIT = 7;
  localparam int RI_BIT   = 4;
  localparam int TO_BIT   = 3;
  localparam int PD_BIT   = 2;
  localparam int POR_BIT  = 1;
  localparam int BOR_BIT  = 0;
  localparam logic [7:0] RESET_CAUSE_CONTROL_MASK    = 8'h9f;
  localparam logic [7:0] RESET_CAUSE_CONTROL_RESET   = 8'h1c;
  localparam logic [4:0] FLAGS_POR    = 5'h1c;
  localparam logic [4:0] FLAGS_BOR    = 5'h1e;

  // configuration register layout
  localparam int CFG_DLYDIS_BIT = 0;
  localparam int CFG_BROWNOUT_ENABLE_BIT  = 1;
  localparam int CFG_PLL_BIT    = 2;
  localparam int CFG_MODE_LSB   = 4;
  localparam logic [6:0] CFG_RESET = 7'h32;

  // stack flag register layout
  localparam int STK_OVF_BIT = 0;
  localparam int STK_UNF_BIT = 1;

  // program counter values
  localparam int PC_W = 21;
  localparam logic [20:0] PC_RESET   = 21'h000000;
  localparam logic [20:0] VEC_HIGH   = 21'h000008;
  localparam logic [20:0] VEC_LOW    = 21'h000018;
  localparam logic [20:0] PC_STEP    = 21'h000002;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RC_PERIOD_NS    = 1000;
  localparam int RC_DIV_CYCLES   = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int POWERUP_TIMER_DELAY_MS   = 72;
  localparam int POWERUP_TIMER_TICKS_DEF  = POWERUP_TIMER_DELAY_MS * 1000000 / RC_PERIOD_NS;
  localparam int PLL_WAIT_MS     = 2;
  localparam int PLL_TICKS_DEF   = PLL_WAIT_MS * 1000000 / RC_PERIOD_NS;
  localparam int EC_RECOVERY_NS  = 1500;
  localparam int EC_REC_CYCLES   =
    (EC_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_CYCLES      = 1024;
  localparam int PIN_FILT_CYCLES = 4;

  typedef enum logic [2:0] {
    OSC_RC = 3'h0,
    OSC_EC = 3'h1,
    OSC_LP = 3'h2,
    OSC_XT = 3'h3,
    OSC_HS = 3'h4
  } rtseq_osc_type;

  typedef enum logic [6:0] {
    ST_RUN   = 7'h01,
    ST_BROWN = 7'h02,
    ST_POWERUP_TIMER  = 7'h04,
    ST_OST   = 7'h08,
    ST_PLL   = 7'h10,
    ST_ECREC = 7'h20,
    ST_SHORT = 7'h40
  } rtseq_state_type;

endpackage

// >>> tb/rtseq_partner.sv
// partner model: supply monitor, reset pin with pull-up, crystal
// assumes bench commands change just after hclk rises
`timescale 1ns/10ps
module rtseq_partner (
  input  wire logic hclk,
  input  wire logic sleep_active,
  input  wire logic pin_hold,
  input  wire logic brown_cmd,
  input  wire logic rise_cmd,
  output logic      osc_input,
  output logic      ext_reset_pin_n,
  output logic      supply_below_threshold,
  output logic      supply_rise_detect
);
  // pull-up: pin reads high unless the outside party holds it
  assign ext_reset_pin_n        = ~pin_hold;
  assign supply_below_threshold = brown_cmd;
  // a supply rise in mid-run stands for a power-on without hresetn
  assign supply_rise_detect     = rise_cmd;
  initial osc_input = 1'b0;
  // crystal stops in sleep, so a crystal-mode wake would wait forever
  always @(posedge hclk) begin
    if (!sleep_active) begin
      osc_input <= ~osc_input;
    end
  end
endmodule

// >>> tb/rtseq_tb_top.sv
// bench for the reset sequencer: bus tasks and one task per scenario
// assumes rtseq_top with short timer counts and the partner model
`timescale 1ns/10ps
module rtseq_tb_top;
  import rtseq_pkg::*;
  logic            hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic            hwrite = 1'b0, sleep_active = 1'b0, sw_req = 1'b0;
  logic            wdog = 1'b0, stk_ovf = 1'b0, wake = 1'b0;
  logic            gie_h = 1'b0, pin_hold = 1'b0, brown_cmd = 1'b0;
  logic            rise_cmd = 1'b0;
  logic [7:0]      haddr = 8'h00;
  logic [1:0]      htrans = 2'h0;
  logic [2:0]      hsize = 3'h2;
  logic [31:0]     hwdata = 32'h0, hrdata;
  logic            hreadyout, hresp, osc_input, pin_n, below, rise;
  logic [PC_W-1:0] pc_cur = 21'h000100, pc_value;
  logic            chip_reset, wake_stall, pc_load;
  int              fails = 0, n_checks = 0, n;

  always #5 hclk = ~hclk;

  rtseq_top #(.POWERUP_TIMER_TICKS(3), .PLL_TICKS(2)) rtseq_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .supply_rise_detect(rise),
    .supply_below_threshold(below), .ext_reset_pin_n(pin_n),
    .osc_input(osc_input), .sleep_active(sleep_active),
    .sw_reset_req(sw_req), .wdog_expiry(wdog), .stack_overflow(stk_ovf),
    .stack_underflow(1'b0), .int_wake(wake), .int_wake_high(1'b1),
    .high_priority_global_enable(gie_h),
    .low_priority_global_enable(1'b0), .pc_current(pc_cur),
    .chip_reset(chip_reset), .wake_stall(wake_stall), .pc_load(pc_load),
    .pc_value(pc_value));

  rtseq_partner rtseq_partner_i (
    .hclk(hclk), .sleep_active(sleep_active), .pin_hold(pin_hold),
    .brown_cmd(brown_cmd), .rise_cmd(rise_cmd), .osc_input(osc_input),
    .ext_reset_pin_n(pin_n), .supply_below_threshold(below),
    .supply_rise_detect(rise));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp);
    chk(hresp, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask

  // bounded waits; the count in n is judged by the caller
  task automatic wait_load;
    n = 0;
    while (pc_load !== 1'b1 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic wait_rel;
    n = 0;
    while (chip_reset !== 1'b0 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic s_power;
    chk(chip_reset, 1'b1);
    rchk(ADDR_RESET_CAUSE_CONTROL, 32'h1c);
    rchk(ADDR_CFG, 32'h32);
    rchk(8'h10, 32'h0);
    wait_rel;
    chk(n >= 2200 && n <= 2600, 1'b1);
  endtask

  // k picks the cause: 0 software, 1 watchdog, 2 stack overflow
  task automatic ev(input int k, input logic [31:0] pre, exp);
    wr(ADDR_RESET_CAUSE_CONTROL, pre);
    case (k)
      0: sw_req <= 1'b1;
      1: wdog <= 1'b1;
      default: stk_ovf <= 1'b1;
    endcase
    @(posedge hclk);
    sw_req <= 1'b0;
    wdog <= 1'b0;
    stk_ovf <= 1'b0;
    wait_load;
    chk(pc_load, 1'b1);
    chk(pc_value, 32'h0);
    rchk(ADDR_RESET_CAUSE_CONTROL, exp);
  endtask

  task automatic s_pin;
    wr(ADDR_RESET_CAUSE_CONTROL, 32'h94);
    pin_hold <= 1'b1;
    repeat (2) @(posedge hclk);
    pin_hold <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(chip_reset, 1'b0);
    pin_hold <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(chip_reset, 1'b1);
    pin_hold <= 1'b0;
    wait_load;
    chk(pc_value, 32'h0);
    rchk(ADDR_RESET_CAUSE_CONTROL, 32'h14);
  endtask

  task automatic s_wake(input logic [31:0] cfg, input logic g,
                        input logic [PC_W-1:0] pc, input int lo, hi);
    wr(ADDR_CFG, cfg);
    sleep_active <= 1'b1;
    gie_h <= g;
    @(posedge hclk);
    wake <= 1'b1;
    @(posedge hclk);
    wake <= 1'b0;
    @(posedge hclk);
    chk(wake_stall, 1'b1);
    chk(chip_reset, 1'b0);
    wait_load;
    chk(pc_value, pc);
    chk(n >= lo && n <= hi, 1'b1);
    sleep_active <= 1'b0;
    rchk(ADDR_RESET_CAUSE_CONTROL, 32'h18);
  endtask

  task automatic s_brown(input logic [31:0] cfg, input int lo, hi);
    wr(ADDR_CFG, cfg);
    brown_cmd <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(chip_reset, cfg[1]);
    brown_cmd <= 1'b0;
    wait_rel;
    chk(n >= lo && n <= hi, 1'b1);
    if (cfg[1]) rchk(ADDR_RESET_CAUSE_CONTROL, 32'h1e);
  endtask

  // supply rise in mid-run: full time-out and power-on flag values
  task automatic s_por;
    wr(ADDR_RESET_CAUSE_CONTROL, 32'h9f);
    rise_cmd <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(chip_reset, 1'b1);
    rise_cmd <= 1'b0;
    wait_rel;
    chk(n >= 2200 && n <= 2600, 1'b1);
    rchk(ADDR_RESET_CAUSE_CONTROL, 32'h1c);
  endtask

  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_power;
    ev(0, 32'hfc, 32'h0c);
    ev(1, 32'h8c, 32'h14);
    ev(2, 32'h94, 32'h14);
    rchk(ADDR_STACK, 32'h1);
    s_pin;
    s_wake(32'h02, 1'b1, VEC_HIGH, 0, 6);
    s_wake(32'h12, 1'b0, pc_cur + PC_STEP, 145, 160);
    s_brown(32'h32, 200, 2600);
    s_brown(32'h03, 0, 6);
    s_brown(32'h30, 0, 0);
    s_por;
    summarize;
  end

  // the whole run needs about 7500 cycles; 60000 leaves ample margin
  initial begin
    #600000;
    fails++;
    summarize;
  end
endmodule
